// ---- src/reg_file_mem.v ----
// 256 x 8 register file with registered read data
`timescale 1ns/1ps
`default_nettype none
module reg_file_mem (
  input wire i_sys_clk,
  input wire [7:0] i_rd_addr,
  output reg [7:0] o_rd_data,
  input wire i_we,
  input wire [7:0] i_wr_addr,
  input wire [7:0] i_wr_data
);
  reg [7:0] mem [0:255];
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule
`default_nettype wire

// ---- src/rot_unit_consts.vh ----
// constants for the rotate and bank select execution unit
`ifndef ROT_UNIT_CONSTS_VH
`define ROT_UNIT_CONSTS_VH
`define OPC_RLC_DIR 8'h10
`define OPC_RLC_IND 8'h11
`define OPC_RR_DIR 8'hE0
`define OPC_RR_IND 8'hE1
`define OPC_RRC_DIR 8'hC0
`define OPC_RRC_IND 8'hC1
`define OPC_SEL_LOW_BANK 8'h4F
`define FLG_C 7
`define FLG_Z 6
`define FLG_S 5
`define FLG_V 4
`define FLG_D 3
`define FLG_H 2
`define FLG_BANK 0
`define FLAGS_RST 8'h00
`define ROT_CYCLES 3'h4
`define SEL_BANK_CYCLES 3'h4
`endif

// ---- src/rotate_unit.v ----
// rotate through carry, plain rotate right and low bank select execution unit
`timescale 1ns/1ps
`default_nettype none
`include "rot_unit_consts.vh"
// Behaviour
// - left rotate: carry into bit0, bit7 out
// - left via carry: opcodes 10/11, 4 cycles
// - plain right: bit0 to bit7 and carry
// - plain right: opcodes E0/E1, 4 cycles
// - right via carry: carry in bit7
// - right via carry: opcodes C0/C1, 4 cycles
// - zero flag set when result zero
// - sign is result bit7; D,H kept
// - overflow when bit7 changed by rotation
// - low bank select clears flags bit0
// - bank select: 4F, 4 cycles, flags 7:1 kept
module rotate_unit (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_start,
  input wire [7:0] i_opcode,
  input wire [7:0] i_operand,
  input wire i_flags_we,
  input wire [7:0] i_flags_wdata,
  input wire i_host_we,
  input wire [7:0] i_host_addr,
  input wire [7:0] i_host_wdata,
  output wire [7:0] o_host_rdata,
  output reg [7:0] o_flags,
  output reg o_busy,
  output reg o_done,
  output reg o_bad_opcode,
  output reg [7:0] o_result
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;

  localparam K_NONE = 2'h0;
  localparam K_RLC = 2'h1;
  localparam K_RR = 2'h2;
  localparam K_RRC = 2'h3;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] cnt_r;
  reg [1:0] kind_r;
  reg ind_r;
  reg bank_op_r;
  reg [7:0] opnd_r;
  reg [7:0] dst_r;
  reg [7:0] core_rd_addr;
  reg core_we;
  reg [8:0] rot;
  reg [7:0] flags_nxt;
  wire [7:0] rd_data;
  wire [7:0] mem_rd_addr;
  wire mem_we;
  wire [7:0] mem_wr_addr;
  wire [7:0] mem_wr_data;

  // decode: kind of rotate, 0 when not a rotate opcode
  function [1:0] rot_kind;
    input [7:0] opc;
    begin
      case (opc)
        `OPC_RLC_DIR, `OPC_RLC_IND: rot_kind = K_RLC;
        `OPC_RR_DIR, `OPC_RR_IND: rot_kind = K_RR;
        `OPC_RRC_DIR, `OPC_RRC_IND: rot_kind = K_RRC;
        default: rot_kind = K_NONE;
      endcase
    end
  endfunction

  // {carry out, result}
  function [8:0] rotate;
    input [1:0] kind;
    input [7:0] v;
    input c;
    begin
      case (kind)
        K_RLC: rotate = {v[7], v[6:0], c};
        K_RR: rotate = {v[0], v[0], v[7:1]};
        K_RRC: rotate = {v[0], c, v[7:1]};
        default: rotate = {c, v};
      endcase
    end
  endfunction

  // last run phase; each instruction class keeps its own cycle count
  function [2:0] last_phase;
    input bank;
    begin
      if (bank) begin
        last_phase = `SEL_BANK_CYCLES - 3'h1;
      end else begin
        last_phase = `ROT_CYCLES - 3'h1;
      end
    end
  endfunction

  // the direct and indirect forms differ only in the low opcode bit
  wire start_ok = (state_r == ST_IDLE) && i_start;
  wire [1:0] dec_kind = rot_kind(i_opcode);
  wire dec_bank = (i_opcode == `OPC_SEL_LOW_BANK);
  // phase 2 has the target value on the read port: result, write back and flags
  wire upd_phase = (state_r == ST_RUN) && (cnt_r == 3'h2);
  // unknown opcodes still run the full count, so timing never depends on decode
  wire run_last = (state_r == ST_RUN) && (cnt_r == last_phase(bank_op_r));

  always @* begin
    rot = rotate(kind_r, rd_data, o_flags[`FLG_C]);
  end

  // read port: phase 1 re-reads through the pointer for indirect mode
  always @* begin
    core_rd_addr = opnd_r;
    if (cnt_r == 3'h1 && ind_r) begin
      core_rd_addr = rd_data;
    end
  end

  always @* begin
    core_we = upd_phase && (kind_r != K_NONE);
  end

  // next flags: a core load between instructions, or the phase 2 update
  always @* begin
    flags_nxt = o_flags;
    if ((state_r == ST_IDLE) && !i_start && i_flags_we) begin
      // a load in mid instruction is dropped, not deferred, so it never races the update
      flags_nxt = i_flags_wdata;
    end
    if (upd_phase) begin
      if (kind_r != K_NONE) begin
        flags_nxt[`FLG_C] = rot[8];
        flags_nxt[`FLG_Z] = (rot[7:0] == 8'h00);
        flags_nxt[`FLG_S] = rot[7];
        flags_nxt[`FLG_V] = rot[7] ^ rd_data[7];
      end else if (bank_op_r) begin
        flags_nxt[`FLG_BANK] = 1'b0;
      end
    end
  end

  // host reaches the register file only while the unit is idle
  assign mem_rd_addr = (state_r == ST_RUN) ? core_rd_addr :
                       (start_ok ? i_operand : i_host_addr);
  assign mem_we = core_we | ((state_r == ST_IDLE) & i_host_we & ~i_start);
  assign mem_wr_addr = core_we ? dst_r : i_host_addr;
  assign mem_wr_data = core_we ? rot[7:0] : i_host_wdata;
  assign o_host_rdata = rd_data;

  // one read port serves host and core, so the host sees internal reads while busy
  // read data is registered, so every pointer hop costs one phase
  reg_file_mem u_mem (
    .i_sys_clk(i_sys_clk),
    .i_rd_addr(mem_rd_addr),
    .o_rd_data(rd_data),
    .i_we(mem_we),
    .i_wr_addr(mem_wr_addr),
    .i_wr_data(mem_wr_data)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (run_last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // the register file is not cleared by reset; software must set it up
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      kind_r <= K_NONE;
      ind_r <= 1'b0;
      bank_op_r <= 1'b0;
      opnd_r <= 8'h00;
      dst_r <= 8'h00;
      o_flags <= `FLAGS_RST;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_bad_opcode <= 1'b0;
      o_result <= 8'h00;
    end else begin
      state_r <= state_nxt;
      o_done <= 1'b0;
      if (start_ok) begin
        cnt_r <= 3'h1;
        kind_r <= dec_kind;
        ind_r <= i_opcode[0];
        bank_op_r <= dec_bank;
        opnd_r <= i_operand;
        o_busy <= 1'b1;
        o_bad_opcode <= (dec_kind == K_NONE) && !dec_bank;
      end else if (state_r == ST_RUN) begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h1) begin
          dst_r <= ind_r ? rd_data : opnd_r;
        end
        if (run_last) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
      end
      // flags and result change only once per instruction, at phase 2
      o_flags <= flags_nxt;
      if (upd_phase && (kind_r != K_NONE)) begin
        o_result <= rot[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/rotate_unit_chk.sv ----
// checker for the rotate unit ports
`timescale 1ns/1ps
`default_nettype none
module rotate_unit_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] o_flags,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [7:0] o_result
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  wire go = i_start && !o_busy;
  wire rot = go && (i_opcode inside {8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1});
  wire low = go && i_opcode == 8'h4F;
  sequence s_run;
    o_busy [*3] ##1 (o_done && !o_busy);
  endsequence
  a_run_time: assert property (go |=> s_run) else $error("run");
  a_bank_clear: assert property (low |-> ##3 !o_flags[0]) else $error("bank");
  a_bank_keeps: assert property (
    low |-> ##3 o_flags[7:1] == $past(o_flags[7:1], 3)) else $error("keep");
  a_rot_keeps: assert property (
    rot |-> ##3 o_flags[3:0] == $past(o_flags[3:0], 3)) else $error("dh");
  a_zero_flag: assert property (
    rot |-> ##3 o_flags[6] == (o_result == 8'h00)) else $error("zero");
  a_sign_flag: assert property (rot |-> ##3 o_flags[5] == o_result[7]) else $error("sign");
  // the original bit 7 is the new carry on a left rotate, result bit 6 on a right one
  a_ovf_flag: assert property (
    rot |-> ##3 o_flags[4] == (o_result[7] ^ ($past(i_opcode[7], 3) ? o_result[6] : o_flags[7])))
    else $error("ovf");
  a_rr_carry: assert property (
    go && i_opcode[7:1] == 7'h70 |-> ##3 o_flags[7] == o_result[7]) else $error("carry");
endmodule
bind rotate_unit rotate_unit_chk rotate_unit_chk_inst (.i_sys_clk, .i_reset, .i_start,
  .i_opcode, .o_flags, .o_busy, .o_done, .o_result);
`default_nettype wire

// ---- tb/rotate_unit_tb.sv ----
// self-checking bench for the rotate unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module rotate_unit_tb;
  logic i_sys_clk = 0, i_reset = 1, i_start = 0, i_flags_we = 0, i_host_we = 0;
  logic [7:0] i_opcode = 0, i_operand = 0, i_host_addr = 0, i_host_wdata = 0;
  wire [7:0] i_flags_wdata = i_host_wdata;
  wire [7:0] o_host_rdata, o_flags, o_result;
  wire o_busy, o_done, o_bad_opcode;
  int n_mismatch = 0, n_compared = 0;
  rotate_unit rotate_unit_inst (.i_sys_clk, .i_reset, .i_start, .i_opcode, .i_operand,
    .i_flags_we, .i_flags_wdata, .i_host_we, .i_host_addr, .i_host_wdata, .o_host_rdata,
    .o_flags, .o_busy, .o_done, .o_bad_opcode, .o_result);
  // f selects a flag load instead of a register write
  task automatic w(input logic f, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_host_we <= !f;
    i_flags_we <= f;
    i_host_addr <= a;
    i_host_wdata <= d;
    @(posedge i_sys_clk);
    i_host_we <= 0;
    i_flags_we <= 0;
  endtask
  task automatic r(input logic [7:0] op, opr, a, m, f);
    logic bad;
    bad = !(op inside {8'h10, 8'h11, 8'hE0, 8'hE1, 8'hC0, 8'hC1, 8'h4F});
    @(posedge i_sys_clk);
    i_start <= 1;
    i_opcode <= op;
    i_operand <= opr;
    @(posedge i_sys_clk);
    i_start <= 0;
    repeat (3) @(posedge i_sys_clk);
    #1;
    `CHK("done", 1'b1, o_done)
    `CHK("flags", f, o_flags)
    `CHK("bad", bad, o_bad_opcode)
    if (op != 8'h4F) `CHK("result", m, o_result)
    @(posedge i_sys_clk);
    i_host_addr <= a;
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK("reg", m, o_host_rdata)
  endtask
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    #20000;
    n_mismatch++;
    results;
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset <= 0;
    w(1, 0, 8'h0D);
    w(0, 8'h00, 8'hAA);
    w(0, 8'h01, 8'h02);
    w(0, 8'h02, 8'h17);
    w(0, 8'h03, 8'h31);
    w(0, 8'h05, 8'h80);
    r(8'h10, 8'h00, 8'h00, 8'h54, 8'h9D);
    r(8'h11, 8'h01, 8'h02, 8'h2F, 8'h0D);
    r(8'hE0, 8'h03, 8'h03, 8'h98, 8'hBD);
    r(8'hE1, 8'h01, 8'h02, 8'h97, 8'hBD);
    r(8'hC0, 8'h00, 8'h00, 8'hAA, 8'h3D);
    r(8'h4F, 8'h00, 8'h00, 8'hAA, 8'h3C);
    r(8'hC1, 8'h01, 8'h02, 8'h4B, 8'h9C);
    w(1, 0, 8'h00);
    r(8'h10, 8'h05, 8'h05, 8'h00, 8'hD0);
    r(8'h55, 8'h05, 8'h05, 8'h00, 8'hD0);
    r(8'h4F, 8'h00, 8'h01, 8'h02, 8'hD0);
    results;
  end
endmodule
`default_nettype wire
